// >>> core/cswk_pkg.sv
// Package for the selective wake mode control block.
// Assumes one 200 MHz clock and plain control ports, no register bus.
package cswk_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	// Bus silence time in microseconds, plain default
	localparam int SILENCE_US = 1000;
	localparam int SILENCE_CYCLES = SILENCE_US * CLK_MHZ;
	localparam int PIN_SYNC_STAGES = 3;

	// ---------------------------------------------------------------
	// Mode field layout and codes
	// ---------------------------------------------------------------
	localparam int MODE_W = 3;
	localparam int MODE_SWK_BIT = 2;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_WAKE = 3'h1;
	localparam logic [2:0] MODE_RX_ONLY = 3'h2;
	localparam logic [2:0] MODE_NORMAL = 3'h3;
	localparam logic [2:0] MODE_OFF_ALT = 3'h4;
	localparam logic [2:0] MODE_SWK = 3'h5;
	localparam logic [2:0] MODE_SWK_RX = 3'h6;
	localparam logic [2:0] MODE_SWK_NORMAL = 3'h7;
	localparam logic [2:0] MODE_RESET = 3'h0;

	// ---------------------------------------------------------------
	// Device operating modes, driven by the device mode logic
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		CSWK_DEV_NORMAL = 4'h1,
		CSWK_DEV_STOP = 4'h2,
		CSWK_DEV_SLEEP = 4'h4,
		CSWK_DEV_RESTART = 4'h8
	} cswk_dev_mode_t;

	// ---------------------------------------------------------------
	// Selective wake detection states
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		CSWK_ST_IDLE = 5'h01,
		CSWK_ST_FRAME_DET = 5'h02,
		CSWK_ST_PAT_DET1 = 5'h04,
		CSWK_ST_PAT_DET2 = 5'h08,
		CSWK_ST_WOKEN = 5'h10
	} cswk_state_t;

	// ---------------------------------------------------------------
	// Host write strobes, one-cycle pulses
	// ---------------------------------------------------------------
	typedef struct packed {
		logic mode_wr;
		logic [2:0] mode_data;
		logic cfg_valid_set;
		logic cfg_reg_wr;
		logic ctrl_reg_wr;
		logic swk_config_error_flag_clr;
		logic timeout_clr;
	} cswk_host_t;

	// ---------------------------------------------------------------
	// Events from the frame decoder and error counter, pulses
	// ---------------------------------------------------------------
	typedef struct packed {
		logic valid_frame;
		logic protocol_error;
		logic wake_frame;
		logic wake_pattern;
		logic count_overflow;
	} cswk_bus_evt_t;

endpackage

// >>> core/cswk_mode_ctrl.sv
// Selective wake mode control: mode field, config check, status flags.
// Assumes the decoder, error counter and device mode logic share ref_clk;
// only the bus receive pin arrives asynchronously.
//
// Overview of operation
// - Config error flag sets on configuration error and on error counter overflow.
// - Config error flag sets only while mode field top bit is one.
// - Interrupt pulse low whenever config error flag sets, unless bus group masked.
// - Config error flag zero after reset; host may clear it.
// - Enabling selective wake runs check: pass clears flag, fail sets it.
// - Normal mode config register writes drop config-valid; Stop and Sleep refuse them.
// - Restart drops config-valid; sets error flag unless woken by wake frame.
// - Error flag clear refused while top mode bit set and config-valid zero.
// - Writes only to the wake control register keep config-valid.
// - Timeout flag sets on silence expiry in frame or second pattern detection.
// - Each timeout event interrupts in Stop or Normal when enabled.
// - A timeout never requests a wake from Sleep.
// - Silence flag sets on silence expiry, clears on wake pattern.
// - Sync flag sets on valid frame, clears on protocol error, limited states.
// - Low-power entry with selective wake allowed while sync flag is zero.
// - Wake active flag set on correct enable or after error; cleared on wake.
// - Mode field writes ignored in Stop and Sleep; host programs it in Normal.
// - Mode codes decode to off, wake, receive-only, normal, and wake variants.
// - Normal with selective wake transmits, monitors, wake interrupt, receive line kept.
// - Receive-only with selective wake forwards data, never transmits.
// - Mode read returns programmed mode in Normal.
// - Stop with error flag set runs wake modes without frame detection.
// - Error counter overflow disables selective wake, wakes, sets error flag.
`timescale 1ns/100ps
`default_nettype none

module cswk_mode_ctrl #(
	parameter int SILENCE_CYCLES = cswk_pkg::SILENCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire cswk_pkg::cswk_dev_mode_t dev_mode,
	input wire cswk_pkg::cswk_host_t host,
	input wire cswk_pkg::cswk_bus_evt_t bus_evt,
	input wire logic restart_by_wake_frame,
	input wire logic bus_status_irq_mask,
	input wire logic bus_timeout_irq_enable,
	input wire logic bus_rx_pin,
	output logic [2:0] mode_rd_ff,
	output logic swk_config_error_flag_ff,
	output logic config_valid_bit_ff,
	output logic bus_timeout_flag_ff,
	output logic bus_silence_flag_ff,
	output logic frame_sync_flag_ff,
	output logic wake_active_flag_ff,
	output logic interrupt_out_low_ff,
	output logic wake_req_ff,
	output logic frame_det_en_ff,
	output logic tx_en_ff,
	output logic rx_fwd_en_ff,
	output cswk_pkg::cswk_state_t swk_state_ff
);

	localparam int CNT_W = $clog2(SILENCE_CYCLES + 1);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [cswk_pkg::PIN_SYNC_STAGES-1:0] rx_sync_ff;
	logic rx_level_ff;
	logic bus_activity;
	logic [CNT_W-1:0] silence_cnt_ff;
	logic silence_expire;
	logic silence_run;
	logic in_normal;
	logic in_stop;
	logic in_low_power;
	logic mode_write_ok;
	logic [2:0] nxt_mode;
	logic swk_sel;
	logic nxt_swk_sel;
	logic swk_enable_evt;
	logic cfg_wr_normal;
	logic restart_entry;
	cswk_pkg::cswk_dev_mode_t dev_mode_ff;
	logic swk_config_error_flag_set;
	logic swk_config_error_flag_clr_ok;
	logic frame_wake;
	logic pattern_wake;
	logic timeout_evt;
	cswk_pkg::cswk_state_t nxt_state;

	// ---------------------------------------------------------------
	// Bus pin synchroniser and activity detect
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rx_sync_ff <= '1;
		end else begin
			rx_sync_ff <= {rx_sync_ff[cswk_pkg::PIN_SYNC_STAGES-2:0], bus_rx_pin};
		end
	end

	// Level accepted once second and third stage agree
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rx_level_ff <= 1'b1;
		end else if (rx_sync_ff[1] == rx_sync_ff[2]) begin
			rx_level_ff <= rx_sync_ff[2];
		end
	end

	assign bus_activity = (rx_sync_ff[1] == rx_sync_ff[2]) && (rx_sync_ff[2] != rx_level_ff);

	// ---------------------------------------------------------------
	// Mode decode helpers
	// ---------------------------------------------------------------
	assign in_normal = (dev_mode == cswk_pkg::CSWK_DEV_NORMAL);
	assign in_stop = (dev_mode == cswk_pkg::CSWK_DEV_STOP);
	assign in_low_power = in_stop || (dev_mode == cswk_pkg::CSWK_DEV_SLEEP);
	assign restart_entry = (dev_mode == cswk_pkg::CSWK_DEV_RESTART)
		&& (dev_mode_ff != cswk_pkg::CSWK_DEV_RESTART);
	assign mode_write_ok = host.mode_wr && !in_low_power;
	assign nxt_mode = mode_write_ok ? host.mode_data : mode_rd_ff;
	// wake modes are 101, 110, 111
	assign swk_sel = mode_rd_ff[cswk_pkg::MODE_SWK_BIT] && (mode_rd_ff[1:0] != 2'h0);
	assign nxt_swk_sel = nxt_mode[cswk_pkg::MODE_SWK_BIT] && (nxt_mode[1:0] != 2'h0);
	// check on each write that selects a new wake mode, or any wake mode once woken
	assign swk_enable_evt = mode_write_ok && nxt_swk_sel
		&& ((nxt_mode != mode_rd_ff) || (swk_state_ff == cswk_pkg::CSWK_ST_WOKEN));
	// config writes only count in Normal
	assign cfg_wr_normal = host.cfg_reg_wr && in_normal;

	// ---------------------------------------------------------------
	// Wake and timeout events
	// ---------------------------------------------------------------
	assign frame_wake = (swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET) && bus_evt.wake_frame;
	assign pattern_wake = (swk_state_ff == cswk_pkg::CSWK_ST_PAT_DET2) && bus_evt.wake_pattern;
	assign silence_run = (swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET)
		|| (swk_state_ff == cswk_pkg::CSWK_ST_PAT_DET2);
	assign timeout_evt = silence_run && silence_expire;

	// ---------------------------------------------------------------
	// Silence timer
	// ---------------------------------------------------------------
	// counted silence time
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			silence_cnt_ff <= '0;
		end else if (!silence_run || bus_activity || silence_expire) begin
			silence_cnt_ff <= '0;
		end else begin
			silence_cnt_ff <= silence_cnt_ff + 1'b1;
		end
	end

	assign silence_expire = (silence_cnt_ff == CNT_W'(SILENCE_CYCLES - 1));

	// ---------------------------------------------------------------
	// Mode field and device mode history
	// ---------------------------------------------------------------
	// stored field is the programmed mode
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			mode_rd_ff <= cswk_pkg::MODE_RESET;
		end else begin
			mode_rd_ff <= nxt_mode;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			dev_mode_ff <= cswk_pkg::CSWK_DEV_NORMAL;
		end else begin
			dev_mode_ff <= dev_mode;
		end
	end

	// ---------------------------------------------------------------
	// Config-valid bit
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			config_valid_bit_ff <= 1'b0;
		end else if (restart_entry) begin
			config_valid_bit_ff <= 1'b0;
		end else if (cfg_wr_normal) begin
			config_valid_bit_ff <= 1'b0;
		end else if (host.cfg_valid_set && !in_low_power) begin
			config_valid_bit_ff <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Config error flag
	// ---------------------------------------------------------------
	// config error or overflow
	always_comb begin
		swk_config_error_flag_set = 1'b0;
		if (mode_rd_ff[cswk_pkg::MODE_SWK_BIT]) begin
			if (bus_evt.count_overflow && (swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET)) begin
				swk_config_error_flag_set = 1'b1;
			end
			if (cfg_wr_normal && swk_sel) begin
				swk_config_error_flag_set = 1'b1;
			end
			// restart not caused by wake frame
			if (restart_entry && swk_sel && !restart_by_wake_frame) begin
				swk_config_error_flag_set = 1'b1;
			end
		end
		if (swk_enable_evt && !config_valid_bit_ff) begin
			swk_config_error_flag_set = 1'b1;
		end
	end

	assign swk_config_error_flag_clr_ok = host.swk_config_error_flag_clr
		&& !(mode_rd_ff[cswk_pkg::MODE_SWK_BIT] && !config_valid_bit_ff);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			swk_config_error_flag_ff <= 1'b0;
		end else if (swk_config_error_flag_set) begin
			swk_config_error_flag_ff <= 1'b1;
		end else if (swk_enable_evt && config_valid_bit_ff) begin
			swk_config_error_flag_ff <= 1'b0;
		end else if (swk_config_error_flag_clr_ok) begin
			swk_config_error_flag_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Detection state machine
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = swk_state_ff;
		unique case (swk_state_ff)
			cswk_pkg::CSWK_ST_IDLE: begin
				nxt_state = cswk_pkg::CSWK_ST_IDLE;
			end
			cswk_pkg::CSWK_ST_FRAME_DET: begin
				if (frame_wake || bus_evt.count_overflow) begin
					nxt_state = cswk_pkg::CSWK_ST_WOKEN;
				end else if (silence_expire) begin
					nxt_state = cswk_pkg::CSWK_ST_PAT_DET1;
				end
			end
			cswk_pkg::CSWK_ST_PAT_DET1: begin
				if (bus_evt.wake_pattern) begin
					nxt_state = cswk_pkg::CSWK_ST_FRAME_DET;
				end
			end
			cswk_pkg::CSWK_ST_PAT_DET2: begin
				if (pattern_wake) begin
					nxt_state = cswk_pkg::CSWK_ST_WOKEN;
				end
			end
			cswk_pkg::CSWK_ST_WOKEN: begin
				nxt_state = cswk_pkg::CSWK_ST_WOKEN;
			end
		endcase
		if (!nxt_swk_sel) begin
			nxt_state = cswk_pkg::CSWK_ST_IDLE;
		end else if (swk_enable_evt) begin
			nxt_state = config_valid_bit_ff ? cswk_pkg::CSWK_ST_FRAME_DET
				: cswk_pkg::CSWK_ST_PAT_DET2;
		end else if (swk_config_error_flag_set && (swk_state_ff != cswk_pkg::CSWK_ST_WOKEN)
				&& (nxt_state != cswk_pkg::CSWK_ST_WOKEN)) begin
			nxt_state = cswk_pkg::CSWK_ST_PAT_DET2;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			swk_state_ff <= cswk_pkg::CSWK_ST_IDLE;
		end else begin
			swk_state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------------------------
	// Timeout and silence flags
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bus_timeout_flag_ff <= 1'b0;
		end else if (timeout_evt) begin
			bus_timeout_flag_ff <= 1'b1;
		end else if (host.timeout_clr) begin
			bus_timeout_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bus_silence_flag_ff <= 1'b0;
		end else if (timeout_evt) begin
			bus_silence_flag_ff <= 1'b1;
		end else if (bus_evt.wake_pattern) begin
			bus_silence_flag_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Sync flag
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			frame_sync_flag_ff <= 1'b0;
		end else if (bus_evt.valid_frame && (mode_rd_ff[1]
				|| (swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET))) begin
			frame_sync_flag_ff <= 1'b1;
		end else if (bus_evt.protocol_error) begin
			frame_sync_flag_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Wake active flag
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wake_active_flag_ff <= 1'b0;
		end else if (!nxt_mode[cswk_pkg::MODE_SWK_BIT]
				|| (nxt_state == cswk_pkg::CSWK_ST_WOKEN)) begin
			// cleared on wake or top bit low
			wake_active_flag_ff <= 1'b0;
		end else if ((nxt_state != swk_state_ff) && (nxt_state != cswk_pkg::CSWK_ST_IDLE)) begin
			// set on correct enable or error
			wake_active_flag_ff <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt and wake request
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			interrupt_out_low_ff <= 1'b1;
		end else begin
			interrupt_out_low_ff <= 1'b1;
			if (swk_config_error_flag_set && !bus_status_irq_mask) begin
				interrupt_out_low_ff <= 1'b0;
			end
			if (timeout_evt && bus_timeout_irq_enable && (in_normal || in_stop)) begin
				interrupt_out_low_ff <= 1'b0;
			end
			if ((frame_wake || pattern_wake) && (in_normal || in_stop)) begin
				interrupt_out_low_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wake_req_ff <= 1'b0;
		end else begin
			wake_req_ff <= (frame_wake || pattern_wake
				|| (bus_evt.count_overflow && (swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET)))
				&& (dev_mode == cswk_pkg::CSWK_DEV_SLEEP);
		end
	end

	// ---------------------------------------------------------------
	// Transceiver enables
	// ---------------------------------------------------------------
	// error flag masks frame detection in Stop
	// entry not gated by sync flag
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			frame_det_en_ff <= 1'b0;
		end else begin
			frame_det_en_ff <= swk_sel && !swk_config_error_flag_ff
				&& (swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tx_en_ff <= 1'b0;
			rx_fwd_en_ff <= 1'b0;
		end else begin
			tx_en_ff <= (mode_rd_ff[1:0] == 2'h3) && !(dev_mode == cswk_pkg::CSWK_DEV_SLEEP);
			rx_fwd_en_ff <= mode_rd_ff[1] && !(dev_mode == cswk_pkg::CSWK_DEV_SLEEP);
		end
	end

endmodule

`default_nettype wire

// >>> verification/cswk_mode_ctrl_chk.sv
// Checker for the selective wake mode control block, bound to its top.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cswk_mode_ctrl_chk #(
	parameter int SILENCE_CYCLES = cswk_pkg::SILENCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire cswk_pkg::cswk_dev_mode_t dev_mode,
	input wire cswk_pkg::cswk_host_t host,
	input wire cswk_pkg::cswk_bus_evt_t bus_evt,
	input wire logic bus_status_irq_mask,
	input wire logic bus_timeout_irq_enable,
	input wire logic [2:0] mode_rd_ff,
	input wire logic swk_config_error_flag_ff,
	input wire logic config_valid_bit_ff,
	input wire logic bus_timeout_flag_ff,
	input wire logic bus_silence_flag_ff,
	input wire logic frame_sync_flag_ff,
	input wire logic wake_active_flag_ff,
	input wire logic interrupt_out_low_ff,
	input wire logic wake_req_ff,
	input wire cswk_pkg::cswk_state_t swk_state_ff
);
	logic in_norm, in_low, in_sleep, in_rst, st_fd, st_p2, st_run;
	assign in_norm = dev_mode == cswk_pkg::CSWK_DEV_NORMAL;
	assign in_sleep = dev_mode == cswk_pkg::CSWK_DEV_SLEEP;
	assign in_low = in_sleep || dev_mode == cswk_pkg::CSWK_DEV_STOP;
	assign in_rst = dev_mode == cswk_pkg::CSWK_DEV_RESTART;
	assign st_fd = swk_state_ff == cswk_pkg::CSWK_ST_FRAME_DET;
	assign st_p2 = swk_state_ff == cswk_pkg::CSWK_ST_PAT_DET2;
	assign st_run = st_fd || st_p2;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence err_rise;
		$rose(swk_config_error_flag_ff) && !bus_status_irq_mask;
	endsequence
	sequence low_pulse;
		!interrupt_out_low_ff ##1 interrupt_out_low_ff;
	endsequence

	err_irq_a: assert property (err_rise |-> low_pulse)
		else $error("no interrupt pulse after config error");
	err_swk_only_a: assert property (
		!mode_rd_ff[2] && !swk_config_error_flag_ff && !(host.mode_wr && host.mode_data[2])
		|=> !swk_config_error_flag_ff) else $error("config error set outside wake modes");
	clr_refused_a: assert property (host.swk_config_error_flag_clr && mode_rd_ff[2] &&
		!config_valid_bit_ff && swk_config_error_flag_ff |=> swk_config_error_flag_ff)
		else $error("config error cleared without config valid");
	mode_locked_a: assert property (host.mode_wr && in_low |=> $stable(mode_rd_ff))
		else $error("mode changed in low power");
	cfg_drop_a: assert property (host.cfg_reg_wr && in_norm |=> !config_valid_bit_ff)
		else $error("config valid kept after config write");
	restart_cv_a: assert property (in_rst && !$past(in_rst) |=> !config_valid_bit_ff)
		else $error("config valid kept on restart");
	to_irq_a: assert property ($rose(bus_timeout_flag_ff) && bus_timeout_irq_enable &&
		(in_norm || dev_mode == cswk_pkg::CSWK_DEV_STOP) |-> low_pulse)
		else $error("no timeout interrupt");
	to_sil_a: assert property ($rose(bus_timeout_flag_ff) |-> bus_silence_flag_ff &&
		$past(st_run)) else $error("timeout without silence in detect state");
	to_no_wake_a: assert property ($rose(bus_timeout_flag_ff) |=> !wake_req_ff)
		else $error("wake request on timeout");
	sync_clr_a: assert property (
		bus_evt.protocol_error && !bus_evt.valid_frame |=> !frame_sync_flag_ff)
		else $error("sync flag kept after protocol error");
	ovf_err_a: assert property (bus_evt.count_overflow && st_fd |=>
		swk_config_error_flag_ff && !wake_active_flag_ff) else $error("overflow not handled");
	wake_sleep_a: assert property (bus_evt.wake_frame && st_fd && in_sleep |=>
		!wake_active_flag_ff && wake_req_ff) else $error("sleep wake frame not handled");
endmodule

bind cswk_mode_ctrl cswk_mode_ctrl_chk #(.SILENCE_CYCLES(SILENCE_CYCLES)) i_chk (
	.ref_clk(ref_clk), .rstn(rstn), .dev_mode(dev_mode), .host(host), .bus_evt(bus_evt),
	.bus_status_irq_mask(bus_status_irq_mask), .bus_timeout_irq_enable(bus_timeout_irq_enable),
	.mode_rd_ff(mode_rd_ff), .swk_config_error_flag_ff(swk_config_error_flag_ff),
	.config_valid_bit_ff(config_valid_bit_ff), .bus_timeout_flag_ff(bus_timeout_flag_ff),
	.bus_silence_flag_ff(bus_silence_flag_ff), .frame_sync_flag_ff(frame_sync_flag_ff),
	.wake_active_flag_ff(wake_active_flag_ff), .interrupt_out_low_ff(interrupt_out_low_ff),
	.wake_req_ff(wake_req_ff), .swk_state_ff(swk_state_ff)
);
`default_nettype wire

// >>> verification/cswk_can_node.sv
// Model of the CAN side: decoder and counter events plus the receive pin.
// Assumes the bench calls its tasks; each event lasts one ref_clk cycle.
`timescale 1ns/100ps
`default_nettype none
module cswk_can_node (
	input wire logic ref_clk,
	output var cswk_pkg::cswk_bus_evt_t bus_evt,
	output var logic bus_rx_pin
);
	initial begin
		bus_evt = '0;
		bus_rx_pin = 1'b1;
	end
	// Event bit k after gap quiet cycles
	task automatic ev(input int k, input int gap);
		cswk_pkg::cswk_bus_evt_t e;
		e = '0;
		e[k] = 1'b1;
		repeat (gap + 1) @(posedge ref_clk);
		bus_evt <= e;
		@(posedge ref_clk);
		bus_evt <= '0;
	endtask
	// Short dominant burst, recessive high otherwise
	task automatic act();
		@(posedge ref_clk);
		bus_rx_pin <= 1'b0;
		repeat (2) @(posedge ref_clk);
		bus_rx_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> verification/can_selective_wake_mode_control_bench.sv
// Self-checking bench for the selective wake mode control block.
// Assumes the CAN side model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module can_selective_wake_mode_control_bench;
	localparam int SIL = 20;
	localparam int H_TC = 0, H_SC = 1, H_CT = 2, H_CR = 3, H_CV = 4, H_WM = 8;
	localparam int E_OVF = 0, E_PAT = 1, E_WF = 2, E_PERR = 3, E_VF = 4;
	logic ref_clk, rstn, rst_by_wf, irq_mask, to_irq_en, bus_rx_pin;
	logic err_f, cv_f, to_f, sil_f, sync_f, wa_f, irq_n, wreq, fde, txe, rxe;
	logic [2:0] mode_rd;
	cswk_pkg::cswk_dev_mode_t dev_mode;
	cswk_pkg::cswk_host_t host;
	cswk_pkg::cswk_bus_evt_t bus_evt;
	cswk_pkg::cswk_state_t st;
	int n_mismatch, checks;

	cswk_mode_ctrl #(.SILENCE_CYCLES(SIL)) i_dut (
		.ref_clk(ref_clk), .rstn(rstn), .dev_mode(dev_mode), .host(host), .bus_evt(bus_evt),
		.restart_by_wake_frame(rst_by_wf), .bus_status_irq_mask(irq_mask),
		.bus_timeout_irq_enable(to_irq_en), .bus_rx_pin(bus_rx_pin), .mode_rd_ff(mode_rd),
		.swk_config_error_flag_ff(err_f), .config_valid_bit_ff(cv_f),
		.bus_timeout_flag_ff(to_f), .bus_silence_flag_ff(sil_f), .frame_sync_flag_ff(sync_f),
		.wake_active_flag_ff(wa_f), .interrupt_out_low_ff(irq_n), .wake_req_ff(wreq),
		.frame_det_en_ff(fde), .tx_en_ff(txe), .rx_fwd_en_ff(rxe), .swk_state_ff(st)
	);
	cswk_can_node i_can (.ref_clk(ref_clk), .bus_evt(bus_evt), .bus_rx_pin(bus_rx_pin));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
		checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic hp(input int k, input logic [2:0] m);
		cswk_pkg::cswk_host_t h;
		h = '0;
		h[k] = 1'b1;
		h.mode_data = m;
		@(posedge ref_clk);
		host <= h;
		@(posedge ref_clk);
		host <= '0;
	endtask
	task automatic dm(input cswk_pkg::cswk_dev_mode_t d);
		@(posedge ref_clk);
		dev_mode <= d;
	endtask
	task automatic rst();
		@(posedge ref_clk);
		rstn <= 1'b0;
		dev_mode <= cswk_pkg::CSWK_DEV_NORMAL;
		irq_mask <= 1'b0;
		rst_by_wf <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
	endtask
	task automatic arm(input logic [2:0] m);
		hp(H_CV, 3'h0);
		hp(H_WM, m);
		tick(1);
		chk("mode", 5'(m), 5'(mode_rd));
		chk("err", 5'h0, 5'(err_f));
		chk("state", 5'(cswk_pkg::CSWK_ST_FRAME_DET), 5'(st));
		chk("wake_act", 5'h1, 5'(wa_f));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_codes();
		rst();
		hp(H_CV, 3'h0);
		for (int c = 0; c < 8; c++) begin
			hp(H_WM, 3'(c));
			tick(2);
			chk("mode", 5'(c), 5'(mode_rd));
			chk("tx_en", 5'(c[1:0] == 2'h3), 5'(txe));
			chk("rx_fwd", 5'(c[1]), 5'(rxe));
		end
	endtask
	task automatic t_fail(input logic m);
		rst();
		irq_mask <= m;
		hp(H_WM, 3'h5);
		tick(0);
		chk("err", 5'h1, 5'(err_f));
		chk("state", 5'(cswk_pkg::CSWK_ST_PAT_DET2), 5'(st));
		chk("irq_n", 5'(m), 5'(irq_n));
		hp(H_SC, 3'h0);
		tick(1);
		chk("err", 5'h1, 5'(err_f));
		hp(H_CV, 3'h0);
		hp(H_SC, 3'h0);
		tick(1);
		chk("err", 5'h0, 5'(err_f));
	endtask
	task automatic t_silence();
		int i;
		rst();
		to_irq_en <= 1'b1;
		arm(3'h5);
		i_can.act();
		for (i = 0; i < 4 * SIL && to_f !== 1'b1; i++) tick(1);
		if (i == 4 * SIL) begin
			n_mismatch++;
			conclude();
		end
		chk("silence", 5'h1, 5'(sil_f));
		chk("state", 5'(cswk_pkg::CSWK_ST_PAT_DET1), 5'(st));
		chk("irq_n", 5'h0, 5'(irq_n));
		hp(H_TC, 3'h0);
		i_can.ev(E_PAT, 3);
		tick(1);
		chk("timeout", 5'h0, 5'(to_f));
		chk("silence", 5'h0, 5'(sil_f));
	endtask
	task automatic t_wake(input logic slp);
		rst();
		rst_by_wf <= slp;
		arm(3'h7);
		if (slp) dm(cswk_pkg::CSWK_DEV_SLEEP);
		i_can.ev(E_WF, 0);
		tick(0);
		chk("wake_act", 5'h0, 5'(wa_f));
		chk("state", 5'(cswk_pkg::CSWK_ST_WOKEN), 5'(st));
		chk("irq_n", 5'(slp), 5'(irq_n));
		chk("wake_req", 5'(slp), 5'(wreq));
		dm(cswk_pkg::CSWK_DEV_RESTART);
		tick(1);
		chk("cfg_valid", 5'h0, 5'(cv_f));
		chk("err", 5'(!slp), 5'(err_f));
	endtask
	task automatic t_stop(input logic bad);
		rst();
		if (!bad) hp(H_CV, 3'h0);
		hp(H_WM, 3'h7);
		dm(cswk_pkg::CSWK_DEV_STOP);
		hp(H_WM, 3'h3);
		hp(H_CR, 3'h0);
		tick(1);
		chk("mode", 5'h7, 5'(mode_rd));
		chk("frame_det", 5'(!bad), 5'(fde));
		chk("cfg_valid", 5'(!bad), 5'(cv_f));
	endtask
	task automatic t_cfg();
		rst();
		arm(3'h6);
		hp(H_CT, 3'h0);
		tick(1);
		chk("cfg_valid", 5'h1, 5'(cv_f));
		hp(H_CR, 3'h0);
		tick(1);
		chk("cfg_valid", 5'h0, 5'(cv_f));
		chk("err", 5'h1, 5'(err_f));
	endtask
	task automatic t_ovf();
		rst();
		hp(H_WM, 3'h3);
		i_can.ev(E_VF, 0);
		tick(1);
		chk("sync", 5'h1, 5'(sync_f));
		i_can.ev(E_PERR, 2);
		tick(1);
		chk("sync", 5'h0, 5'(sync_f));
		arm(3'h5);
		dm(cswk_pkg::CSWK_DEV_STOP);
		tick(1);
		chk("frame_det", 5'h1, 5'(fde));
		i_can.ev(E_OVF, 0);
		tick(1);
		chk("err", 5'h1, 5'(err_f));
		chk("wake_act", 5'h0, 5'(wa_f));
	endtask

	initial begin
		n_mismatch = 0;
		checks = 0;
		rstn = 1'b0;
		host = '0;
		dev_mode = cswk_pkg::CSWK_DEV_NORMAL;
		rst_by_wf = 1'b0;
		irq_mask = 1'b0;
		to_irq_en = 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		tick(1);
		chk("err", 5'h0, 5'(err_f));
		chk("irq_n", 5'h1, 5'(irq_n));
		chk("state", 5'(cswk_pkg::CSWK_ST_IDLE), 5'(st));
		t_codes();
		t_fail(1'b0);
		t_fail(1'b1);
		t_silence();
		t_wake(1'b0);
		t_wake(1'b1);
		t_stop(1'b0);
		t_stop(1'b1);
		t_cfg();
		t_ovf();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
